/* inc/adc_result_pkg.sv */
package adc_result_pkg;
	// Result geometry.
	localparam int          RES_W        = 10;
	localparam logic [9:0]  CODE_MAX     = 10'h3FF;
	localparam logic [9:0]  CODE_ZERO    = 10'h000;
	localparam logic [9:0]  BIP_MIN      = 10'h200;
	localparam logic [9:0]  BIP_MAX      = 10'h1FF;
	localparam int          SIGN_POS     = 9;
	// Reference select encodings.
	localparam logic [1:0]  REF_INT_1V1  = 2'h2;
	// Gain select encodings.
	localparam logic [1:0]  GAIN_1X      = 2'h0;
	localparam logic [1:0]  GAIN_8X      = 2'h1;
	localparam logic [1:0]  GAIN_20X     = 2'h2;
	localparam logic [1:0]  GAIN_32X     = 2'h3;
	localparam logic [5:0]  GAIN_1X_VAL  = 6'h01;
	localparam logic [5:0]  GAIN_8X_VAL  = 6'h08;
	localparam logic [5:0]  GAIN_20X_VAL = 6'h14;
	localparam logic [5:0]  GAIN_32X_VAL = 6'h20;
	// Conversion types.
	localparam logic [1:0]  CONV_SINGLE  = 2'h0;
	localparam logic [1:0]  CONV_DIFF    = 2'h1;
	// Calibration bytes in the signature row.
	localparam logic [7:0]  SIG_OFFSET_BIG   = 8'h05;
	localparam logic [7:0]  SIG_GAIN_BIG     = 8'h07;
	localparam logic [7:0]  SIG_OFFSET_SMALL = 8'h1F;
	localparam logic [7:0]  SIG_GAIN_SMALL   = 8'h1E;
	// Signature read window: last arm count, so loads are taken for four enabled clock cycles.
	localparam logic [1:0]  SIG_WINDOW   = 2'h3;
	// Reset values.
	localparam logic [9:0]  RES_RST      = 10'h000;
	localparam logic [7:0]  BYTE_RST     = 8'h00;
	typedef enum logic [2:0] {
		SIG_IDLE = 3'b001,
		SIG_ARM  = 3'b010,
		SIG_READ = 3'b100
	} sig_state_t;
endpackage

/* verilog/adc_result_format.sv */
`timescale 1ns/1ps
module adc_result_format
	import adc_result_pkg::*;
#(
	parameter logic SMALL_VARIANT = 1'b0
)(
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        clk_en_i,
	// Converter core side.
	input  wire logic        core_done_i,
	input  wire logic [10:0] core_diff_i,
	input  wire logic [9:0]  core_single_i,
	input  wire logic        conv_type_i,
	input  wire logic [1:0]  gain_sel_i,
	input  wire logic        bipolar_select_i,
	input  wire logic [1:0]  reference_select_i,
	input  wire logic        left_justify_i,
	input  wire logic        flag_clear_i,
	// Signature row access.
	input  wire logic        sig_write_i,
	input  wire logic        signature_read_request_i,
	input  wire logic        store_program_enable_i,
	input  wire logic        program_memory_load_i,
	input  wire logic [7:0]  load_addr_i,
	input  wire logic [7:0]  sensor_offset_constant_i,
	input  wire logic [7:0]  sensor_gain_constant_i,
	// Outputs.
	output logic             conversion_done_flag_o,
	output logic [7:0]       result_low_byte_o,
	output logic [7:0]       result_high_byte_o,
	output logic             result_sign_bit_o,
	output logic             ref_internal_1v1_o,
	output logic             store_program_enable_o,
	output logic [7:0]       load_data_o,
	output logic             load_valid_o
);

	// Gain lookup used by both differential paths.
	function automatic logic [5:0] gain_value(input logic [1:0] sel);
		case (sel)
			GAIN_1X:  gain_value = GAIN_1X_VAL;
			GAIN_8X:  gain_value = GAIN_8X_VAL;
			GAIN_20X: gain_value = GAIN_20X_VAL;
			GAIN_32X: gain_value = GAIN_32X_VAL;
			default:  gain_value = GAIN_1X_VAL;
		endcase
	endfunction

	logic [9:0]  result_reg;
	logic [9:0]  result_next;
	logic        done_reg;
	logic [7:0]  low_reg;
	logic [7:0]  high_reg;
	logic        sign_reg;
	logic        ref_reg;
	sig_state_t  sig_state_reg;
	sig_state_t  sig_state_next;
	logic [1:0]  sig_cnt_reg;
	logic        spm_reg;
	logic [7:0]  load_data_reg;
	logic        load_valid_reg;

	// Differential difference scaled by gain; a 17-bit product covers 1023*32 both signs.
	wire logic [5:0]         gain_w      = gain_value(gain_sel_i);
	wire logic signed [16:0] scaled_w    = 17'($signed(core_diff_i)) * $signed({11'h000, gain_w});
	wire logic signed [16:0] uni_max_w   = 17'sh003FF;
	wire logic signed [16:0] bip_max_w   = 17'sh001FF;
	wire logic signed [16:0] bip_min_w   = -17'sh00200;
	wire logic signed [16:0] half_w      = scaled_w >>> 1;

	// Unipolar clamps negatives to zero and large values to full scale.
	wire logic [9:0] uni_code_w = scaled_w[16] ? CODE_ZERO :
		(scaled_w > uni_max_w) ? CODE_MAX : scaled_w[9:0];

	// Bipolar uses half the scale so the sign fits in the top bit.
	wire logic [9:0] bip_code_w = (half_w > bip_max_w) ? BIP_MAX :
		(half_w < bip_min_w) ? BIP_MIN : half_w[9:0];

	// Mode selection; the core already delivers single-ended codes in range.
	wire logic [9:0] conv_code_w = (conv_type_i == CONV_SINGLE[0]) ? core_single_i :
		(bipolar_select_i ? bip_code_w : uni_code_w);

	// Result is replaced only when a conversion completes.
	assign result_next = core_done_i ? conv_code_w : result_reg;

	// Justification is combinational from the stored result; the byte outputs take a change on the next enabled clock.
	wire logic [7:0] low_w  = left_justify_i ? {result_reg[1:0], 6'h00} : result_reg[7:0];
	wire logic [7:0] high_w = left_justify_i ? result_reg[9:2] : {6'h00, result_reg[9:8]};

	// Signature address decode depends on device variant.
	wire logic [7:0] off_addr_w  = SMALL_VARIANT ? SIG_OFFSET_SMALL : SIG_OFFSET_BIG;
	wire logic [7:0] gain_addr_w = SMALL_VARIANT ? SIG_GAIN_SMALL : SIG_GAIN_BIG;
	wire logic       arm_w       = sig_write_i && signature_read_request_i &&
		store_program_enable_i && !spm_reg;
	wire logic       load_hit_w  = (sig_state_reg == SIG_ARM) && program_memory_load_i;

	// Signature read sequencer: arm, then accept a load within the window.
	always_comb begin
		sig_state_next = sig_state_reg;
		case (sig_state_reg)
			SIG_IDLE: begin
				if (arm_w) begin
					sig_state_next = SIG_ARM;
				end
			end
			SIG_ARM: begin
				if (load_hit_w) begin
					sig_state_next = SIG_READ;
				end else if (sig_cnt_reg == SIG_WINDOW) begin
					sig_state_next = SIG_IDLE;
				end
			end
			SIG_READ: begin
				// Enable is already clear here, so a new arm write is taken at once.
				sig_state_next = arm_w ? SIG_ARM : SIG_IDLE;
			end
			default:  sig_state_next = SIG_IDLE;
		endcase
	end

	// Constants are passed raw: gain unsigned 1/128 units, offset signed byte.
	wire logic [7:0] sig_byte_w = (load_addr_i == off_addr_w) ? sensor_offset_constant_i :
		(load_addr_i == gain_addr_w) ? sensor_gain_constant_i : BYTE_RST;

	// Result and flag storage; a new completion wins over a software clear.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			result_reg <= RES_RST;
			done_reg   <= 1'b0;
		end else if (clk_en_i) begin
			result_reg <= result_next;
			done_reg   <= core_done_i | (done_reg & ~flag_clear_i);
		end
	end

	// Output byte registers track the stored result and justify bit.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			low_reg  <= BYTE_RST;
			high_reg <= BYTE_RST;
			sign_reg <= 1'b0;
			ref_reg  <= 1'b0;
		end else if (clk_en_i) begin
			low_reg  <= low_w;
			high_reg <= high_w;
			sign_reg <= result_reg[SIGN_POS];
			ref_reg  <= (reference_select_i == REF_INT_1V1);
		end
	end

	// Signature sequencer registers; enable bit clears after the read or timeout.
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			sig_state_reg  <= SIG_IDLE;
			sig_cnt_reg    <= 2'h0;
			spm_reg        <= 1'b0;
			load_data_reg  <= BYTE_RST;
			load_valid_reg <= 1'b0;
		end else if (clk_en_i) begin
			sig_state_reg  <= sig_state_next;
			sig_cnt_reg    <= (sig_state_reg == SIG_ARM) ? sig_cnt_reg + 2'h1 : 2'h0;
			spm_reg        <= (sig_state_next == SIG_ARM);
			load_valid_reg <= load_hit_w;
			if (load_hit_w) begin
				load_data_reg <= sig_byte_w;
			end
		end
	end

	assign conversion_done_flag_o = done_reg;
	assign result_low_byte_o      = low_reg;
	assign result_high_byte_o     = high_reg;
	assign result_sign_bit_o      = sign_reg;
	assign ref_internal_1v1_o     = ref_reg;
	assign store_program_enable_o = spm_reg;
	assign load_data_o            = load_data_reg;
	assign load_valid_o           = load_valid_reg;

endmodule

/* test/adc_result_format_properties.sv */
`timescale 1ns/1ps
module adc_result_format_properties
	import adc_result_pkg::*;
#(
	parameter logic SMALL_VARIANT = 1'b0
)(
	input wire logic       mclk_i,
	input wire logic       rst_n_i,
	input wire logic       clk_en_i,
	input wire logic       core_done_i,
	input wire logic       left_justify_i,
	input wire logic [1:0] reference_select_i,
	input wire logic       sig_write_i,
	input wire logic       signature_read_request_i,
	input wire logic       store_program_enable_i,
	input wire logic       program_memory_load_i,
	input wire logic [7:0] load_addr_i,
	input wire logic [7:0] sensor_offset_constant_i,
	input wire logic       conversion_done_flag_o,
	input wire logic [7:0] result_low_byte_o,
	input wire logic [7:0] result_high_byte_o,
	input wire logic       result_sign_bit_o,
	input wire logic       ref_internal_1v1_o,
	input wire logic       store_program_enable_o,
	input wire logic [7:0] load_data_o,
	input wire logic       load_valid_o
);
	// One clock domain, so clocking and reset masking are shared.
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_arm;
		clk_en_i && sig_write_i && signature_read_request_i && store_program_enable_i
			&& !store_program_enable_o;
	endsequence
	sequence s_quiet;
		!core_done_i && $stable(left_justify_i);
	endsequence
	a_done_flag: assert property (clk_en_i && core_done_i |=> conversion_done_flag_o)
		else $error("done flag not raised");
	a_ref_select: assert property (rst_n_i && clk_en_i |=>
		ref_internal_1v1_o == ($past(reference_select_i) == REF_INT_1V1))
		else $error("reference flag wrong");
	a_result_hold: assert property (s_quiet ##1 s_quiet |=>
		$stable({result_low_byte_o, result_high_byte_o})) else $error("result moved");
	a_right_pack: assert property (rst_n_i && clk_en_i && !left_justify_i |=>
		result_high_byte_o[7:2] == 6'h00 && result_sign_bit_o == result_high_byte_o[1])
		else $error("right pack wrong");
	a_left_pack: assert property (rst_n_i && clk_en_i && left_justify_i |=>
		result_low_byte_o[5:0] == 6'h00 && result_sign_bit_o == result_high_byte_o[7])
		else $error("left pack wrong");
	a_arm_store: assert property (s_arm |=> store_program_enable_o)
		else $error("arm missed");
	a_load_cause: assert property (load_valid_o && $past(clk_en_i) |->
		$past(program_memory_load_i) && $past(store_program_enable_o))
		else $error("load without arm");
	a_offset_byte: assert property (load_valid_o && $past(clk_en_i) &&
		$past(load_addr_i) == (SMALL_VARIANT ? SIG_OFFSET_SMALL : SIG_OFFSET_BIG)
		|-> load_data_o == $past(sensor_offset_constant_i)) else $error("offset byte wrong");
endmodule

bind adc_result_format adc_result_format_properties #(.SMALL_VARIANT(SMALL_VARIANT)) u_props (.*);

/* test/adc_core_model.sv */
`timescale 1ns/1ps
// Core stand-in: code one cycle after start; idle data toggles so stale reads show.
module adc_core_model (
	input  wire logic        mclk_i,
	input  wire logic        start_i,
	input  wire logic [10:0] d_i,
	output logic             done_o = 1'b0,
	output logic [10:0]      diff_o = 11'h000
);
	// Data is only meaningful in the done cycle.
	always @(posedge mclk_i) begin
		done_o <= start_i;
		diff_o <= start_i ? d_i : ~diff_o;
	end
endmodule

/* test/adc_result_format_tb.sv */
`timescale 1ns/1ps
module adc_result_format_tb;
	import adc_result_pkg::*;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, start = 1'b0, core_done_i;
	logic conv_type_i = 1'b0, bipolar_select_i = 1'b0, left_justify_i = 1'b0;
	logic flag_clear_i = 1'b0, sig_write_i = 1'b0, signature_read_request_i = 1'b0;
	logic store_program_enable_i = 1'b0, program_memory_load_i = 1'b0;
	logic [1:0] gain_sel_i = GAIN_1X, reference_select_i = 2'h0;
	logic [7:0] load_addr_i = 8'h00, sensor_offset_constant_i = 8'hA5, sensor_gain_constant_i = 8'h7C;
	logic [10:0] d = 11'h000, core_diff_i;
	logic [9:0] core_single_i;
	logic conversion_done_flag_o, result_sign_bit_o, ref_internal_1v1_o;
	logic store_program_enable_o, load_valid_o;
	logic [7:0] result_low_byte_o, result_high_byte_o, load_data_o;
	int n_fail = 0, n_checks = 0;
	assign core_single_i = core_diff_i[9:0];
	adc_result_format dut (.*);
	adc_core_model u_core (.mclk_i, .start_i(start), .d_i(d), .done_o(core_done_i), .diff_o(core_diff_i));
	initial forever #25 mclk_i = ~mclk_i;
	task chk(input string nm, input logic [15:0] g, e);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task test_done;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// One conversion through the core; flag wait is bounded.
	task conv(input logic t, b, input logic [1:0] g, input logic [10:0] dv, input logic [9:0] e);
		@(posedge mclk_i);
		{conv_type_i, bipolar_select_i, gain_sel_i, d, start} <= {t, b, g, dv, 1'b1};
		@(posedge mclk_i);
		start <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(negedge mclk_i);
			if (conversion_done_flag_o === 1'b1) break;
		end
		chk("flag", conversion_done_flag_o, 1'b1);
		if (conversion_done_flag_o !== 1'b1) test_done;
		@(negedge mclk_i);
		chk("result", {result_high_byte_o, result_low_byte_o}, {6'h00, e});
		chk("sign", result_sign_bit_o, e[9]);
		@(posedge mclk_i) flag_clear_i <= 1'b1;
		@(posedge mclk_i) flag_clear_i <= 1'b0;
		$display("conv %h end", e);
	endtask
	// Signature access; late loads fall outside the arm window.
	task sig(input logic [7:0] a, input int late, input logic v, input logic [7:0] e);
		@(posedge mclk_i);
		{sig_write_i, signature_read_request_i, store_program_enable_i} <= 3'h7;
		@(posedge mclk_i);
		{sig_write_i, signature_read_request_i, store_program_enable_i, load_addr_i} <= {3'h0, a};
		@(negedge mclk_i) chk("armed", store_program_enable_o, 1'b1);
		repeat (late) @(posedge mclk_i);
		@(posedge mclk_i) program_memory_load_i <= 1'b1;
		@(posedge mclk_i) program_memory_load_i <= 1'b0;
		@(negedge mclk_i) chk("valid", load_valid_o, v);
		if (v) chk("data", load_data_o, e);
		repeat (8) @(posedge mclk_i);
		$display("sig %h end", a);
	endtask
	// Temperature read: sensor setup, single conversion, software formula on the bytes.
	task temp_test;
		int res, off, t;
		@(posedge mclk_i) {left_justify_i, reference_select_i} <= {1'b0, REF_INT_1V1};
		conv(0, 0, GAIN_1X, 11'h144, 10'h144);
		res = {result_high_byte_o, result_low_byte_o};
		off = $signed(sensor_offset_constant_i);
		t = ((res - (273 + 25 - off)) * 128) / int'(sensor_gain_constant_i) + 25;
		chk("temp", t[15:0], 16'hFFD6);
		$display("temp end");
	endtask
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		conv(0, 0, GAIN_1X, 11'h3FF, 10'h3FF);
		conv(0, 0, GAIN_1X, 11'h000, 10'h000);
		conv(1, 0, GAIN_1X, 11'h005, 10'h005);
		conv(1, 0, GAIN_8X, 11'h005, 10'h028);
		conv(1, 0, GAIN_20X, 11'h005, 10'h064);
		conv(1, 0, GAIN_32X, 11'h040, 10'h3FF);
		conv(1, 0, GAIN_1X, 11'h7FB, 10'h000);
		conv(1, 1, GAIN_1X, 11'h7FC, 10'h3FE);
		conv(1, 1, GAIN_32X, 11'h400, 10'h200);
		conv(1, 1, GAIN_8X, 11'h100, 10'h1FF);
		@(posedge mclk_i) left_justify_i <= 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("left", {result_high_byte_o, result_low_byte_o}, 16'h7FC0);
		repeat (6) @(negedge mclk_i);
		chk("hold", {result_high_byte_o, result_low_byte_o}, 16'h7FC0);
		$display("justify end");
		for (int r = 0; r < 4; r++) begin
			@(posedge mclk_i) reference_select_i <= r[1:0];
			repeat (2) @(negedge mclk_i);
			chk("ref", ref_internal_1v1_o, r == 2);
		end
		$display("ref end");
		sig(SIG_OFFSET_BIG, 0, 1'b1, 8'hA5);
		sig(SIG_GAIN_BIG, 0, 1'b1, 8'h7C);
		sig(8'h10, 0, 1'b1, 8'h00);
		sig(SIG_GAIN_BIG, 6, 1'b0, 8'h00);
		temp_test;
		test_done;
	end
endmodule
